// ===== rtl/sec_map.vh
`ifndef SEC_MAP_VH
`define SEC_MAP_VH

// clock period and self-timed program pulse
`define SEC_CLK_PERIOD_NS 4
`define SEC_T_PROG_NS 10000000
`define SEC_PROG_CYCLES (`SEC_T_PROG_NS / `SEC_CLK_PERIOD_NS)

// array geometry defaults
`define SEC_ADDR_W 6
`define SEC_DATA_W 16
`define SEC_OP_W 2

// primary opcodes, sampled after the start bit
`define SEC_OP_EXT 2'h0
`define SEC_OP_WRITE 2'h1
`define SEC_OP_READ 2'h2
`define SEC_OP_ERASE 2'h3

// extended opcodes, top two address bits when opcode is ext
`define SEC_EXT_DISABLE 2'h0
`define SEC_EXT_FILL 2'h1
`define SEC_EXT_CLEAR 2'h2
`define SEC_EXT_ENABLE 2'h3

// pending programming actions
`define SEC_ACT_WRITE 2'h0
`define SEC_ACT_ERASE 2'h1
`define SEC_ACT_CLEAR 2'h2
`define SEC_ACT_FILL 2'h3

// reset values
`define SEC_PROG_EN_RST 1'h0
`define SEC_SDO_RST 1'h1

`endif

// ===== rtl/sec_sync.v
`timescale 1ns/10ps
// two-stage synchroniser for pin inputs
module sec_sync #(
   parameter W = 3
) (
   input wire clk,
   input wire rst_n,
   input wire clk_en,
   input wire [W-1:0] async_in,
   output wire [W-1:0] sync_out
);
   reg [W-1:0] meta_reg;
   reg [W-1:0] sync_reg;

   // first stage feeds only the second stage
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_reg <= {W{1'b0}};
         sync_reg <= {W{1'b0}};
      end
      else if (clk_en)
      begin
         meta_reg <= async_in;
         sync_reg <= meta_reg;
      end
   end

   assign sync_out = sync_reg;
endmodule // sec_sync

// ===== rtl/sec_prog_timer.v
`timescale 1ns/10ps
`include "sec_map.vh"
// self-timed programming pulse, runs without the serial clock
module sec_prog_timer #(
   parameter CYCLES = `SEC_PROG_CYCLES,
   parameter CNT_W = 24
) (
   input wire clk,
   input wire rst_n,
   input wire clk_en,
   input wire start,
   output wire busy,
   output wire done
);
   reg [CNT_W-1:0] cnt_reg;
   reg busy_reg;
   reg done_reg;

   // count down from start; done pulses once at the end
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_reg <= {CNT_W{1'b0}};
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
      end
      else if (clk_en)
      begin
         done_reg <= 1'b0;
         if (start && !busy_reg)
         begin
            cnt_reg <= CYCLES[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1};
            busy_reg <= 1'b1;
         end
         else if (busy_reg)
         begin
            if (cnt_reg == {CNT_W{1'b0}})
            begin
               busy_reg <= 1'b0;
               done_reg <= 1'b1;
            end
            else
               cnt_reg <= cnt_reg - {{(CNT_W-1){1'b0}}, 1'b1};
         end
      end
   end

   assign busy = busy_reg;
   assign done = done_reg;
endmodule // sec_prog_timer

// ===== rtl/sec_engine.v
// How it works
// - read: leave high-z, dummy zero, word msb first
// - output bit changes on serial clock rise
// - held select plus clocks streams next word
// - sequential address wraps last to zero
// - dummy zero only before first word
// - select fall after write starts timed cycle
// - select high during cycle shows status
// - word write clears location itself
// - erase plus select low clears location
// - erased location reads all ones
// - power up with programming disabled
// - enable holds until disable or power loss
// - disabled: programming commands ignored
// - reads work enabled or disabled
// - clear-all sets whole array to ones
// - fill-all stores word everywhere
// - start bit, opcode, address, data
// - data input sampled on clock rise
// - status low busy, high ready
// - dummy one returns output high-z
`timescale 1ns/10ps
`include "sec_map.vh"
module sec_engine #(
   parameter ADDR_W = `SEC_ADDR_W,
   parameter DATA_W = `SEC_DATA_W,
   parameter PROG_CYCLES = `SEC_PROG_CYCLES,
   parameter TMR_W = 24
) (
   input wire clk,
   input wire rst_n,
   input wire clk_en,
   input wire chip_select,
   input wire serial_clock,
   input wire serial_data_input,
   output wire serial_data_out,
   output wire serial_data_out_en,
   output wire prog_busy,
   output wire prog_enabled
);
   localparam ST_IDLE = 3'h0;
   localparam ST_SHIFT = 3'h1;
   localparam ST_READ = 3'h2;
   localparam ST_ARMED = 3'h3;
   localparam ST_BUSY = 3'h4;
   localparam ST_HOLD = 3'h5;
   localparam SH_W = `SEC_OP_W + ADDR_W + DATA_W;
   localparam [7:0] HDR_BITS = `SEC_OP_W + ADDR_W;
   localparam [7:0] ALL_BITS = `SEC_OP_W + ADDR_W + DATA_W;
   localparam [7:0] WORD_BITS = DATA_W;
   localparam DEPTH = 1 << ADDR_W;

   // the array itself
   reg [DATA_W-1:0] mem [0:DEPTH-1];

   wire [2:0] pins_s;
   wire cs_s;
   wire sclk_s;
   wire sdi_s;
   wire tmr_busy;
   wire tmr_done;

   reg [2:0] state_reg;
   reg sclk_prev_reg;
   reg cs_prev_reg;
   reg [SH_W-1:0] sh_reg;
   reg [7:0] cnt_reg;
   reg [1:0] op_reg;
   reg [1:0] act_reg;
   reg [ADDR_W-1:0] addr_reg;
   reg [DATA_W-1:0] data_reg;
   reg [DATA_W-1:0] rd_sh_reg;
   reg [7:0] rd_cnt_reg;
   reg prog_en_reg;
   reg stat_show_reg;
   reg stat_clr_reg;
   reg tmr_start_reg;
   reg sdo_reg;
   reg sdo_en_reg;

   wire sclk_rise;
   wire sclk_fall;
   wire cs_fall;
   wire [SH_W-1:0] sh_next;
   wire [7:0] cnt_next;
   wire [1:0] op_next;
   wire [1:0] ext_next;
   wire [ADDR_W-1:0] addr_next;
   wire [ADDR_W-1:0] rd_addr_next;
   wire [DATA_W-1:0] rd_word_next;

   // all three pins cross into the clk domain first
   sec_sync #(
      .W(3)
   ) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .async_in({chip_select, serial_clock, serial_data_input}),
      .sync_out(pins_s)
   );

   assign cs_s = pins_s[2];
   assign sclk_s = pins_s[1];
   assign sdi_s = pins_s[0];

   // self-timed cycle runs on clk alone, serial clock may stop
   sec_prog_timer #(
      .CYCLES(PROG_CYCLES),
      .CNT_W(TMR_W)
   ) u_timer (
      .clk(clk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .start(tmr_start_reg),
      .busy(tmr_busy),
      .done(tmr_done)
   );

   // edges of the synchronised pins
   assign sclk_rise = sclk_s & ~sclk_prev_reg;
   assign sclk_fall = ~sclk_s & sclk_prev_reg;
   assign cs_fall = ~cs_s & cs_prev_reg;

   // header fields seen with the bit arriving this edge
   assign sh_next = {sh_reg[SH_W-2:0], sdi_s};
   assign cnt_next = cnt_reg + 8'h01;
   assign op_next = sh_next[ADDR_W+1:ADDR_W];
   assign addr_next = sh_next[ADDR_W-1:0];
   assign ext_next = sh_next[ADDR_W-1:ADDR_W-2];

   // natural overflow of the counter gives the wrap to zero
   assign rd_addr_next = addr_reg + {{(ADDR_W-1){1'b0}}, 1'b1};
   assign rd_word_next = mem[rd_addr_next];

   // edge history
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sclk_prev_reg <= 1'b0;
         cs_prev_reg <= 1'b0;
      end
      else if (clk_en)
      begin
         sclk_prev_reg <= sclk_s;
         cs_prev_reg <= cs_s;
      end
   end

   // command engine
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg <= ST_IDLE;
         sh_reg <= {SH_W{1'b0}};
         cnt_reg <= 8'h00;
         op_reg <= 2'h0;
         act_reg <= 2'h0;
         addr_reg <= {ADDR_W{1'b0}};
         data_reg <= {DATA_W{1'b0}};
         rd_sh_reg <= {DATA_W{1'b0}};
         rd_cnt_reg <= 8'h00;
         prog_en_reg <= `SEC_PROG_EN_RST;
         stat_show_reg <= 1'b0;
         stat_clr_reg <= 1'b0;
         tmr_start_reg <= 1'b0;
         sdo_reg <= `SEC_SDO_RST;
         sdo_en_reg <= 1'b0;
      end
      else if (clk_en)
      begin
         tmr_start_reg <= 1'b0;
         // status view follows the timer while selected
         if (stat_show_reg && cs_s && state_reg != ST_READ)
         begin
            sdo_en_reg <= 1'b1;
            sdo_reg <= ~tmr_busy;
         end
         // dummy one seen: release the pin on the next falling edge
         if (stat_clr_reg && sclk_fall)
         begin
            stat_show_reg <= 1'b0;
            stat_clr_reg <= 1'b0;
            sdo_en_reg <= 1'b0;
         end
         case (state_reg)
            ST_IDLE:
            begin
               // start bit is a one on a rising edge
               if (cs_s && sclk_rise && sdi_s)
               begin
                  state_reg <= ST_SHIFT;
                  cnt_reg <= 8'h00;
                  sh_reg <= {SH_W{1'b0}};
                  if (stat_show_reg)
                     stat_clr_reg <= 1'b1;
               end
            end
            ST_SHIFT:
            begin
               if (!cs_s)
                  state_reg <= ST_IDLE;
               else if (sclk_rise)
               begin
                  sh_reg <= sh_next;
                  cnt_reg <= cnt_next;
                  if (cnt_next == HDR_BITS)
                  begin
                     op_reg <= op_next;
                     addr_reg <= addr_next;
                     case (op_next)
                        `SEC_OP_READ:
                        begin
                           // no enable check on reads
                           state_reg <= ST_READ;
                           stat_show_reg <= 1'b0;
                           stat_clr_reg <= 1'b0;
                           sdo_en_reg <= 1'b1;
                           sdo_reg <= 1'b0;
                           rd_sh_reg <= mem[addr_next];
                           rd_cnt_reg <= WORD_BITS;
                        end
                        `SEC_OP_ERASE:
                        begin
                           act_reg <= `SEC_ACT_ERASE;
                           state_reg <= ST_ARMED;
                        end
                        `SEC_OP_WRITE:
                           state_reg <= ST_SHIFT;
                        `SEC_OP_EXT:
                        begin
                           case (ext_next)
                              `SEC_EXT_ENABLE:
                              begin
                                 prog_en_reg <= 1'b1;
                                 state_reg <= ST_HOLD;
                              end
                              `SEC_EXT_DISABLE:
                              begin
                                 prog_en_reg <= 1'b0;
                                 state_reg <= ST_HOLD;
                              end
                              `SEC_EXT_CLEAR:
                              begin
                                 act_reg <= `SEC_ACT_CLEAR;
                                 state_reg <= ST_ARMED;
                              end
                              default:
                                 state_reg <= ST_SHIFT;
                           endcase
                        end
                        default:
                           state_reg <= ST_HOLD;
                     endcase
                  end
                  else if (cnt_next == ALL_BITS)
                  begin
                     // data field complete for write or fill
                     data_reg <= sh_next[DATA_W-1:0];
                     state_reg <= ST_ARMED;
                     if (op_reg == `SEC_OP_WRITE)
                        act_reg <= `SEC_ACT_WRITE;
                     else
                        act_reg <= `SEC_ACT_FILL;
                  end
               end
            end
            ST_READ:
            begin
               if (!cs_s)
               begin
                  state_reg <= ST_IDLE;
                  sdo_en_reg <= 1'b0;
               end
               else if (sclk_rise)
               begin
                  if (rd_cnt_reg == 8'h00)
                  begin
                     // next word follows with no dummy bit
                     addr_reg <= rd_addr_next;
                     sdo_reg <= rd_word_next[DATA_W-1];
                     rd_sh_reg <= {rd_word_next[DATA_W-2:0], 1'b0};
                     rd_cnt_reg <= WORD_BITS - 8'h01;
                  end
                  else
                  begin
                     sdo_reg <= rd_sh_reg[DATA_W-1];
                     rd_sh_reg <= {rd_sh_reg[DATA_W-2:0], 1'b0};
                     rd_cnt_reg <= rd_cnt_reg - 8'h01;
                  end
               end
            end
            ST_ARMED:
            begin
               // launch on select fall, only while enabled
               if (cs_fall)
               begin
                  if (prog_en_reg)
                  begin
                     tmr_start_reg <= 1'b1;
                     stat_show_reg <= 1'b1;
                     stat_clr_reg <= 1'b0;
                     state_reg <= ST_BUSY;
                  end
                  else
                     state_reg <= ST_IDLE;
               end
            end
            ST_BUSY:
            begin
               // clocks and data are ignored until the store ends
               if (tmr_done)
                  state_reg <= ST_IDLE;
            end
            ST_HOLD:
            begin
               // extra clocks after a short command are ignored
               if (!cs_s)
                  state_reg <= ST_IDLE;
            end
            default:
               state_reg <= ST_IDLE;
         endcase
         // pin floats whenever the part is deselected
         if (!cs_s)
            sdo_en_reg <= 1'b0;
      end
   end

   // array update at the end of the timed cycle; a whole-array
   // action lands in one clock, which costs a wide write port
   integer i;
   always @(posedge clk)
   begin
      if (clk_en && tmr_done)
      begin
         case (act_reg)
            `SEC_ACT_WRITE:
               mem[addr_reg] <= data_reg;
            `SEC_ACT_ERASE:
               mem[addr_reg] <= {DATA_W{1'b1}};
            `SEC_ACT_CLEAR:
            begin
               for (i = 0; i < DEPTH; i = i + 1)
                  mem[i] <= {DATA_W{1'b1}};
            end
            `SEC_ACT_FILL:
            begin
               for (i = 0; i < DEPTH; i = i + 1)
                  mem[i] <= data_reg;
            end
            default:
               mem[addr_reg] <= data_reg;
         endcase
      end
   end

   assign serial_data_out = sdo_reg;
   assign serial_data_out_en = sdo_en_reg;
   assign prog_busy = tmr_busy;
   assign prog_enabled = prog_en_reg;
endmodule // sec_engine

// ===== testbench/sec_engine_assertions.sv
`timescale 1ns/10ps
// pin and status relations of the command engine
module sec_engine_chk #(
   parameter PROG_CYCLES = 20
) (
   input wire clk,
   input wire rst_n,
   input wire clk_en,
   input wire chip_select,
   input wire serial_clock,
   input wire serial_data_input,
   input wire serial_data_out,
   input wire serial_data_out_en,
   input wire prog_busy,
   input wire prog_enabled
);
   // length of the running timed cycle, in clk
   int busy_cnt;
   always @(posedge clk or negedge rst_n)
      if (!rst_n)
         busy_cnt <= 0;
      else
         busy_cnt <= prog_busy ? busy_cnt + 1 : 0;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_power_up_off: assert property (!$past(rst_n) |-> !prog_enabled && !prog_busy)
      else $error("programming not off after reset");
   a_prog_needs_en: assert property ($rose(prog_busy) |-> $past(prog_enabled))
      else $error("timed cycle while disabled");
   a_launch_on_fall: assert property ($rose(prog_busy) |-> !$past(chip_select) &&
      !$past(chip_select, 3))
      else $error("timed cycle not launched by select low");
   a_cycle_length: assert property ($fell(prog_busy) |-> busy_cnt >= PROG_CYCLES - 2 &&
      busy_cnt <= PROG_CYCLES + 2)
      else $error("timed cycle length wrong");
   a_busy_low: assert property (serial_data_out_en && prog_busy |-> !serial_data_out)
      else $error("status not low while busy");
   a_ready_high: assert property ($fell(prog_busy) && chip_select |->
      ##[1:4] serial_data_out_en && serial_data_out)
      else $error("ready status not shown");
   a_quiet_desel: assert property (!chip_select [*6] |-> !serial_data_out_en)
      else $error("output driven while deselected");
   a_bit_on_rise: assert property (serial_data_out_en && $past(serial_data_out_en) &&
      $fell(serial_data_out) |-> $past(serial_clock))
      else $error("output bit moved away from clock rise");
   a_en_steady: assert property ($changed(prog_enabled) |-> !prog_busy &&
      !$past(prog_busy))
      else $error("enable state moved during timed cycle");

   c_cycle_done: cover property ($fell(prog_busy));
   c_disabled: cover property ($fell(prog_enabled));
   c_read_out: cover property ($rose(serial_data_out_en) && !prog_busy);
endmodule // sec_engine_chk

// ===== testbench/sec_host.sv
`timescale 1ns/10ps
// bus master: drives select, serial clock and data, samples the output
module sec_host (
   input wire clk,
   output logic cs,
   output logic sclk,
   output logic sdin,
   input wire dout,
   input wire dout_en
);
   // clock stands low between frames
   initial
   begin
      cs = 1'b0;
      sclk = 1'b0;
      sdin = 1'b0;
   end
   // one 48 ns bit; data set mid-low, output sampled late in the high half
   task automatic shift(input logic b, output logic s);
      sdin = b;
      #12 sclk = 1'b1;
      #22 s = dout_en ? dout : 1'bz;
      #2 sclk = 1'b0;
      #12; // data holds to the bit's end, the next bit replaces it
   endtask
   // start bit, opcode, address and data, msb first
   task automatic send(input logic [31:0] v, input int n);
      logic s;
      cs = 1'b1;
      for (int i = n - 1; i >= 0; i--)
         shift(v[i], s);
   endtask
   // select low well above the minimum, no clocks
   task automatic desel();
      cs = 1'b0;
      repeat (16) @(posedge clk);
      #1;
   endtask
   // poll status with the serial clock still
   task automatic sel();
      cs = 1'b1;
   endtask
endmodule // sec_host

// ===== testbench/sec_engine_test.sv
`timescale 1ns/10ps
module sec_engine_test;
   localparam int PROG = 200;
   logic clk, rst_n, clk_en, en_m;
   wire chip_select, serial_clock, serial_data_input;
   wire serial_data_out, serial_data_out_en, prog_busy, prog_enabled;
   int num_errors = 0;
   int checked = 0;
   int busy_cyc = 0;
   logic [15:0] mem [0:63];

   sec_engine #(.PROG_CYCLES(PROG)) sec_engine_inst (.clk(clk), .rst_n(rst_n),
      .clk_en(clk_en), .chip_select(chip_select), .serial_clock(serial_clock),
      .serial_data_input(serial_data_input), .serial_data_out(serial_data_out),
      .serial_data_out_en(serial_data_out_en), .prog_busy(prog_busy),
      .prog_enabled(prog_enabled));
   sec_host host_inst (.clk(clk), .cs(chip_select), .sclk(serial_clock),
      .sdin(serial_data_input), .dout(serial_data_out), .dout_en(serial_data_out_en));

   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // clock cycles spent inside timed cycles so far
   always @(posedge clk)
      if (prog_busy === 1'b1)
         busy_cyc <= busy_cyc + 1;

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      checked++;
      if (got !== exp)
      begin
         num_errors++;
         $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d, mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // enable or disable frame
   task automatic ena(input logic on);
      host_inst.send({23'h0, 3'b100, on ? 6'h30 : 6'h00}, 9);
      host_inst.desel();
      en_m = on;
      chk(prog_enabled, en_m, "enable state");
   endtask
   // k: 0 write, 1 erase, 2 clear all, 3 fill all; polls status when allowed
   task automatic cmd(input int k, input logic [5:0] a, input logic [15:0] d);
      logic [31:0] v;
      logic s;
      int t;
      int c0;
      v = k == 0 ? {7'h0, 3'b101, a, d} : k == 1 ? {23'h0, 3'b111, a} :
         k == 2 ? {23'h0, 3'b100, 6'h20} : {7'h0, 3'b100, 6'h10, d};
      c0 = busy_cyc;
      host_inst.send(v, (k == 0 || k == 3) ? 25 : 9);
      host_inst.desel();
      t = 0;
      if (!en_m)
      begin
         tick(PROG + 40);
         chk(16'(busy_cyc - c0), 16'h0000, "refused cycle");
      end
      else
      begin
         chk(16'(busy_cyc > c0), 16'h0001, "cycle launch");
         host_inst.sel();
         tick(8);
         chk({serial_data_out_en, serial_data_out}, 2'b10, "busy status");
         while (prog_busy === 1'b1 && t < PROG + 40)
         begin
            tick(1);
            t++;
         end
         tick(4);
         chk({serial_data_out_en, serial_data_out}, 2'b11, "ready status");
         chk(16'(busy_cyc - c0), 16'(PROG), "cycle length");
         host_inst.shift(1'b1, s);
         tick(4);
         chk(serial_data_out_en, 1'b0, "status release");
         host_inst.desel();
         for (int i = 0; i < 64; i++)
            if (k >= 2 || i == a)
               mem[i] = (k == 0 || k == 3) ? d : 16'hffff;
      end
   endtask
   // sequential read of nw words starting at a
   task automatic rd(input logic [5:0] a, input int nw);
      logic s;
      logic [15:0] w;
      host_inst.send({24'h0, 3'b110, a[5:1]}, 8);
      host_inst.shift(a[0], s);
      chk(s, 1'b0, "dummy zero");
      for (int k = 0; k < nw; k++)
      begin
         for (int b = 0; b < 16; b++)
         begin
            host_inst.shift(1'b0, s);
            w = {w[14:0], s};
         end
         chk(w, mem[6'(a + k)], "read word");
      end
      host_inst.desel();
   endtask

   initial
   begin
      #200000;
      num_errors++;
      $display("mismatch at %0t: watchdog expired", $time);
      wrap_up();
   end

   initial
   begin
      clk_en = 1'b1;
      rst_n = 1'b0;
      en_m = 1'b0;
      void'($urandom(32'h3b86));
      repeat (20) @(posedge clk);
      #1 rst_n = 1'b1;
      tick(6);
      chk(prog_enabled, 1'b0, "power-up state");
      cmd(0, 6'h05, 16'h1234);
      ena(1'b1);
      cmd(2, 6'h00, 16'h0000);
      rd(6'h3e, 3);
      cmd(3, 6'h00, 16'($urandom));
      rd(6'($urandom), 2);
      cmd(0, 6'h3f, 16'($urandom));
      cmd(0, 6'h00, 16'($urandom));
      cmd(0, 6'($urandom), 16'($urandom));
      cmd(1, 6'h01, 16'h0000);
      rd(6'h3f, 3);
      ena(1'b0);
      for (int k = 0; k < 4; k++)
         cmd(k, 6'h3f, 16'($urandom));
      rd(6'h3f, 3);
      ena(1'b1);
      rst_n = 1'b0;
      tick(3);
      rst_n = 1'b1;
      tick(6);
      en_m = 1'b0;
      chk(prog_enabled, 1'b0, "enable lost at reset");
      cmd(0, 6'h3f, 16'h0f0f);
      rd(6'h3f, 2);
      // a frozen engine must not take an enable frame
      clk_en = 1'b0;
      host_inst.send({23'h0, 3'b100, 6'h30}, 9);
      host_inst.desel();
      clk_en = 1'b1;
      tick(4);
      chk(prog_enabled, 1'b0, "frozen enable");
      wrap_up();
   end
endmodule // sec_engine_test

bind sec_engine sec_engine_chk #(.PROG_CYCLES(PROG_CYCLES)) sec_engine_chk_inst (
   .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .chip_select(chip_select),
   .serial_clock(serial_clock), .serial_data_input(serial_data_input),
   .serial_data_out(serial_data_out), .serial_data_out_en(serial_data_out_en),
   .prog_busy(prog_busy), .prog_enabled(prog_enabled));
